// file: tb/dual_gpio_tb_top.sv
// self-checking bench for the two-port pin block, random stimulus with corners
// assumes the register port answers one cycle after a read strobe
`timescale 1ns/1ps
module dual_gpio_tb_top;
  logic       clk = 0, rst_n = 0, ce = 1, orst = 0, wr_s = 0, rd_s = 0, fr = 0, sr = 0, prog = 0;
  logic [7:0] addr = 0, wd = 0, b_ext = 0, b_en = 8'hFF, dir, lat, v;
  logic [7:0] rdata, b_out, b_oe, b_pu, b_hy, cmpc, refc, b_pin;
  logic [4:0] a_ext = 0, a_out, a_oe, a_pin, asel;
  logic       t_clk, e_int, wake;
  int         err_total = 0, n_tests = 0;

  dual_gpio i_dut (.CLOCK(clk), .RESETN(rst_n), .CLOCK_ENABLE(ce), .OTHER_RESET(orst),
    .ADDR(addr), .WDATA(wd), .WRITE(wr_s), .READ(rd_s), .RDATA(rdata), .PORT_A_IN(a_pin),
    .PORT_A_OUT(a_out), .PORT_A_OE(a_oe), .PORT_B_IN(b_pin), .PORT_B_OUT(b_out),
    .PORT_B_OE(b_oe), .PORT_B_PULLUP(b_pu), .PORT_B_HYSTERESIS(b_hy), .FIRST_RESULT(fr),
    .SECOND_RESULT(sr), .CMP_CONTROL(cmpc), .REF_CONTROL(refc), .ANALOG_SELECT(asel),
    .PROG_MODE(prog), .TIMER_CLOCK_PIN(t_clk), .EXT_INT_PIN(e_int), .WAKE_REQUEST(wake));
  pin_world i_pins (.clock(clk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .b_pullup(b_pu), .a_ext(a_ext), .b_ext(b_ext), .b_ext_en(b_en), .a_pin(a_pin),
    .b_pin(b_pin));

  // 40 MHz core clock
  initial forever #12.5 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, released on the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so look right after that edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp, what);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // expected port A read: open-drain bit4 can only pull low, analog pins read zero
  function automatic logic [7:0] exp_a(input logic [4:0] d, l, e, m);
    logic [4:0] p;
    p    = (d & e) | (~d & l);
    p[4] = (d[4] | l[4]) & e[4];
    return {3'h0, p & ~m};
  endfunction : exp_a

  function automatic logic [4:0] amask(input logic [2:0] m);
    return (m == 3'h7) ? 5'h00 : (m == 3'h6) ? 5'h07 : 5'h0F;
  endfunction : amask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // watchdog: the tests need under a thousand cycles
  initial begin
    #(25 * 20000);
    err_total++;
    summarize();
  end

  initial begin
    void'($urandom(32'h5139));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    rd(8'h81, 8'hFF, "options");
    rd(8'h85, 8'h1F, "dir a");
    rd(8'h86, 8'hFF, "dir b");
    rd(8'h1F, 8'h00, "cmp");
    rd(8'h9F, 8'h00, "ref");
    rd(8'h40, 8'h00, "hole");
    chk({3'h0, a_oe}, 8'h00, "oe a");
    chk(b_pu, 8'h00, "pullup");
    $display("test reset done");
    // port A with all pins digital; first passes set bit4's latch high and low
    wr(8'h1F, 8'h07);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      a_ext <= 5'($urandom);
      dir = (i < 2) ? 8'h00 : 8'($urandom);
      lat = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      wr(8'h85, dir);
      wr(8'h05, lat);
      idle(5);
      chk({3'h0, a_oe}, {3'h0, ~dir[4:0] & ~{lat[4], 4'h0}}, "oe a");
      chk({3'h0, a_out & a_oe}, {3'h0, lat[4:0] & ~dir[4:0] & 5'h0F}, "out a");
      v = exp_a(dir[4:0], lat[4:0], a_ext, 5'h00);
      chk({7'h0, t_clk}, {7'h0, v[4]}, "timer pin");
      rd(8'h05, exp_a(dir[4:0], lat[4:0], a_ext, 5'h00), "pins a");
      rd(8'h85, {3'h0, dir[4:0]}, "dir a");
    end
    $display("test port a done");
    // every comparator mode; directions still steer the drivers
    wr(8'h85, 8'h1F);
    @(posedge clk);
    a_ext <= 5'h1F;
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      fr <= 1'($urandom);
      sr <= 1'($urandom);
      wr(8'h1F, 8'(m));
      idle(4);
      rd(8'h05, exp_a(5'h1F, 5'h00, 5'h1F, amask(3'(m))), "analog");
      rd(8'h1F, {sr, fr, 2'h0, 4'(m)}, "cmp");
      chk({3'h0, asel}, {3'h0, amask(3'(m))}, "analog sel");
      chk(cmpc, 8'(m), "cmp reg");
      wr(8'h85, 8'h00);
      idle(3);
      chk({4'h0, a_oe[3:0]}, 8'h0F, "oe analog");
      if (m == 6) chk({7'h0, a_out[3]}, {7'h0, fr}, "cmp pin");
      if (m == 6) chk({7'h0, a_oe[4]}, {7'h0, ~sr}, "cmp pin four");
      wr(8'h85, 8'h1F);
    end
    v = 8'($urandom);
    wr(8'h9F, v);
    rd(8'h9F, v & 8'hEF, "ref");
    chk(refc, v & 8'hEF, "ref reg");
    wr(8'h85, 8'h00);
    idle(3);
    chk({7'h0, a_oe[2]}, {7'h0, ~v[6]}, "ref pin");
    wr(8'h85, 8'h1F);
    $display("test comparator done");
    // port B directions, latch, pull-ups and pad hints
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      b_ext <= 8'($urandom);
      prog  <= 1'($urandom);
      dir = (i == 0) ? 8'h00 : 8'($urandom);
      lat = 8'($urandom);
      v   = (i == 1) ? 8'h7F : 8'($urandom);
      wr(8'h86, dir);
      wr(8'h06, lat);
      wr(8'h81, v);
      idle(5);
      chk(b_oe, ~dir, "oe b");
      chk(b_out, lat, "out b");
      chk(b_pu, dir & {8{~v[7]}}, "pullup b");
      chk(b_hy, {{2{prog}}, 5'h00, dir[0]}, "hyst");
      chk({7'h0, e_int}, {7'h0, dir[0] ? b_ext[0] : lat[0]}, "int pin");
      rd(8'h06, (dir & b_ext) | (~dir & lat), "pins b");
      rd(8'h81, v, "options");
    end
    // nothing outside drives: the weak pull-ups alone hold the lines high
    wr(8'h86, 8'hFF);
    wr(8'h81, 8'h7F);
    @(posedge clk);
    b_en <= 8'h00;
    idle(4);
    rd(8'h06, 8'hFF, "pulled");
    @(posedge clk);
    b_en <= 8'hFF;
    idle(4);
    $display("test port b done");
    // change flag: only the upper nibble counts, sticky while mismatched
    for (int k = 0; k < 8; k++) begin
      rd(8'h06, b_ext, "resync");
      wr(8'h0B, 8'h00);
      idle(2);
      chk({7'h0, wake}, 8'h00, "flag clear");
      @(posedge clk);
      b_ext <= b_ext ^ (8'h01 << k);
      idle(5);
      chk({7'h0, wake}, {7'h0, k > 3}, "wake");
      rd(8'h0B, {7'h0, k > 3}, "flag");
      if (k > 3) begin
        wr(8'h0B, 8'h00);
        rd(8'h0B, 8'h01, "sticky");
      end
    end
    $display("test change flag done");
    // other reset keeps the latch; frozen clock enable ignores strobes
    wr(8'h1F, 8'h07);
    wr(8'h05, 8'h0A);
    wr(8'h81, 8'h00);
    @(posedge clk);
    orst <= 1'b1;
    @(posedge clk);
    orst <= 1'b0;
    rd(8'h85, 8'h1F, "dir a other");
    rd(8'h1F, {sr, fr, 6'h00}, "cmp other");
    rd(8'h81, 8'hFF, "opt other");
    chk(refc, 8'h00, "ref other");
    wr(8'h1F, 8'h07);
    wr(8'h85, 8'h00);
    idle(5);
    rd(8'h05, 8'h0A, "latch kept");
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h85, 8'h1F);
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h85, 8'h00, "frozen");
    $display("test other reset done");
    summarize();
  end
endmodule : dual_gpio_tb_top

// file: tb/pin_world.sv
// outside circuitry on the pins: keypad-like drivers and pull resistors
// assumes pad enables are high while the block drives a pin
`timescale 1ns/1ps
module pin_world (
  // clock for the floating-line pattern
  input  wire logic       clock,
  // block pad side
  input  wire logic [4:0] a_out,
  input  wire logic [4:0] a_oe,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe,
  input  wire logic [7:0] b_pullup,
  // outside drivers
  input  wire logic [4:0] a_ext,
  input  wire logic [7:0] b_ext,
  input  wire logic [7:0] b_ext_en,
  // resolved pin levels
  output logic      [4:0] a_pin,
  output logic      [7:0] b_pin
);
  logic [7:0] wander = 8'h00;

  // a released line with no pull wanders on bits 0, 2, 5 and 7 and stays low on bits 1, 3, 4 and 6
  always @(posedge clock) wander <= ~wander ^ 8'h5A;

  // port A: block drive wins, else the outside source; bit4 drives low only
  assign a_pin = (a_oe & a_out) | (~a_oe & a_ext);
  // port B: block, then outside driver, then weak pull-up, else wandering
  assign b_pin = (b_oe & b_out) | (~b_oe & b_ext_en & b_ext)
               | (~b_oe & ~b_ext_en & (b_pullup | wander));
endmodule : pin_world

// file: verilog/dual_gpio.sv
// two general-purpose ports with direction control, pull-ups and change flag
// assumes a byte register port on the core clock and pins from outside the domain
// Summary of operation
// - port A has five latches, five direction bits
// - direction 1 floats pin, 0 drives latch
// - port A read gives pins, write stores latch
// - port A bit four is open drain only
// - comparator-input pins of port A read zero
// - resets set A directions; power-on clears latch
// - directions still steer drivers in analog mode
// - unused upper port A bits read zero
// - port B eight bits, same direction sense
// - port B read gives pins, write stores latch
// - clear pull-up enable bit enables all pull-ups
// - pull-up off whenever pin is output
// - power-on: options all ones, B inputs
// - only upper B input pins detect change
// - mismatch against last read sets change flag
// - change event can wake from sleep
// - mismatch keeps flag set until access, clear
// - change during read may be missed
// - hysteresis on interrupt and programming pins
// - comparator and reference controls reset zero
// - store at cycle end, pins sampled at start
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module dual_gpio (
  // clock, reset, enable
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  input  wire logic       CLOCK_ENABLE,
  input  wire logic       OTHER_RESET,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WRITE,
  input  wire logic       READ,
  output logic      [7:0] RDATA,
  // port A pins
  input  wire logic [4:0] PORT_A_IN,
  output logic      [4:0] PORT_A_OUT,
  output logic      [4:0] PORT_A_OE,
  // port B pins
  input  wire logic [7:0] PORT_B_IN,
  output logic      [7:0] PORT_B_OUT,
  output logic      [7:0] PORT_B_OE,
  output logic      [7:0] PORT_B_PULLUP,
  output logic      [7:0] PORT_B_HYSTERESIS,
  // comparator and reference block
  input  wire logic       FIRST_RESULT,
  input  wire logic       SECOND_RESULT,
  output logic      [7:0] CMP_CONTROL,
  output logic      [7:0] REF_CONTROL,
  output logic      [4:0] ANALOG_SELECT,
  // alternate functions and wake
  input  wire logic       PROG_MODE,
  output logic            TIMER_CLOCK_PIN,
  output logic            EXT_INT_PIN,
  output logic            WAKE_REQUEST
);
  // reset release chain
  logic       reset_stage;
  logic       rst_n;
  // register state
  logic [4:0] latch_a;
  logic [4:0] dir_a;
  logic [7:0] latch_b;
  logic [7:0] dir_b;
  logic [7:0] options;
  // synchronised pins
  logic [4:0] pins_a;
  logic [7:0] pins_b;
  // decode
  logic       wr_port_a;
  logic       wr_port_b;
  logic       wr_dir_a;
  logic       wr_dir_b;
  logic       wr_options;
  logic       wr_cmp;
  logic       wr_ref;
  logic       wr_int;
  logic       rd_port_b;
  logic       port_b_access;
  // steering
  logic [2:0] cmp_mode;
  logic [4:0] analog_mask;
  logic [4:0] drive_a;
  logic [4:0] next_oe_a;
  logic [4:0] read_pins_a;
  logic [7:0] next_pullup;
  logic [7:0] next_hyst;
  logic [7:0] read_mux;
  logic [7:0] cmp_read;
  logic       change_flag;

  // reset is released through two flops, asserted at once
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      reset_stage <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      reset_stage <= 1'b1;
      rst_n       <= reset_stage;
    end
  end

  // pins come from outside and pass two flops before any logic
  sync_2ff #(.WIDTH(gpio_pkg::PORT_A_W)) sync_port_a (
    .clock  (CLOCK),
    .rst_n  (rst_n),
    .enable (CLOCK_ENABLE),
    .d      (PORT_A_IN),
    .q      (pins_a)
  );

  sync_2ff #(.WIDTH(gpio_pkg::PORT_B_W)) sync_port_b (
    .clock  (CLOCK),
    .rst_n  (rst_n),
    .enable (CLOCK_ENABLE),
    .d      (PORT_B_IN),
    .q      (pins_b)
  );

  // write and read decode
  assign wr_port_a     = WRITE && (ADDR == gpio_pkg::OFS_PORT_A);
  assign wr_port_b     = WRITE && (ADDR == gpio_pkg::OFS_PORT_B);
  assign wr_dir_a      = WRITE && (ADDR == gpio_pkg::OFS_DIR_A);
  assign wr_dir_b      = WRITE && (ADDR == gpio_pkg::OFS_DIR_B);
  assign wr_options    = WRITE && (ADDR == gpio_pkg::OFS_OPTIONS);
  assign wr_cmp        = WRITE && (ADDR == gpio_pkg::OFS_CMP_CTRL);
  assign wr_ref        = WRITE && (ADDR == gpio_pkg::OFS_REF_CTRL);
  assign wr_int        = WRITE && (ADDR == gpio_pkg::OFS_INT_CTRL);
  assign rd_port_b     = READ && (ADDR == gpio_pkg::OFS_PORT_B);
  // a port write is a read-modify-write, so it also refreshes the old value
  assign port_b_access = rd_port_b || wr_port_b;

  // comparator mode picks which port A pins are analog
  assign cmp_mode = CMP_CONTROL[gpio_pkg::CMP_MODE_MSB:gpio_pkg::CMP_MODE_LSB];
  assign analog_mask = (cmp_mode == gpio_pkg::CMP_ALL_DIGITAL) ? gpio_pkg::ANALOG_NONE :
                       (cmp_mode == gpio_pkg::CMP_OUTPUTS)     ? gpio_pkg::ANALOG_OUTMODE :
                                                                 gpio_pkg::ANALOG_DEFAULT;

  // comparator results take over pins three and four in output mode
  assign drive_a[2:0] = latch_a[2:0];
  assign drive_a[gpio_pkg::PIN_CMP_THREE] = (cmp_mode == gpio_pkg::CMP_OUTPUTS) ?
      FIRST_RESULT : latch_a[gpio_pkg::PIN_CMP_THREE];
  assign drive_a[gpio_pkg::PIN_OPEN_DRAIN] = (cmp_mode == gpio_pkg::CMP_OUTPUTS) ?
      SECOND_RESULT : latch_a[gpio_pkg::PIN_OPEN_DRAIN];

  // drivers follow the direction bits even on analog pins; software must
  // keep those as inputs and clear directions for comparator outputs
  assign next_oe_a[1:0] = ~dir_a[1:0];
  // reference output claims pin two and floats its digital driver
  assign next_oe_a[gpio_pkg::PIN_REF] = ~dir_a[gpio_pkg::PIN_REF] &&
      !REF_CONTROL[gpio_pkg::REF_OUT_EN_BIT];
  assign next_oe_a[gpio_pkg::PIN_CMP_THREE] = ~dir_a[gpio_pkg::PIN_CMP_THREE];
  // open drain: only a low is ever driven
  assign next_oe_a[gpio_pkg::PIN_OPEN_DRAIN] = ~dir_a[gpio_pkg::PIN_OPEN_DRAIN] &&
      !drive_a[gpio_pkg::PIN_OPEN_DRAIN];

  // analog pins read as zero, the rest read the pin level
  assign read_pins_a = pins_a & ~analog_mask;

  // pull-ups only on input pins and only with the enable bit low
  assign next_pullup = dir_b & {gpio_pkg::PORT_B_W{~options[gpio_pkg::PULLUP_EN_N_BIT]}};

  // hysteresis hints for the pad: interrupt pin as input, programming pins
  always_comb begin
    next_hyst = gpio_pkg::ZERO_BYTE;
    next_hyst[gpio_pkg::PIN_EXT_INT] = dir_b[gpio_pkg::PIN_EXT_INT];
    next_hyst[gpio_pkg::PIN_PROG_CLOCK] = PROG_MODE;
    next_hyst[gpio_pkg::PIN_PROG_DATA] = PROG_MODE;
  end

  // comparator control read shows live results in the top two bits
  always_comb begin
    cmp_read = CMP_CONTROL & gpio_pkg::CMP_CTRL_WR_MASK;
    cmp_read[gpio_pkg::FIRST_RESULT_BIT] = FIRST_RESULT;
    cmp_read[gpio_pkg::SECOND_RESULT_BIT] = SECOND_RESULT;
  end

  // read selection; unmapped addresses read zero
  assign read_mux =
      (ADDR == gpio_pkg::OFS_PORT_A)   ? {3'h0, read_pins_a} :
      (ADDR == gpio_pkg::OFS_PORT_B)   ? pins_b :
      (ADDR == gpio_pkg::OFS_DIR_A)    ? {3'h0, dir_a} :
      (ADDR == gpio_pkg::OFS_DIR_B)    ? dir_b :
      (ADDR == gpio_pkg::OFS_OPTIONS)  ? options :
      (ADDR == gpio_pkg::OFS_CMP_CTRL) ? cmp_read :
      (ADDR == gpio_pkg::OFS_REF_CTRL) ? (REF_CONTROL & gpio_pkg::REF_CTRL_WR_MASK) :
      (ADDR == gpio_pkg::OFS_INT_CTRL) ? {7'h00, change_flag} :
                                         gpio_pkg::ZERO_BYTE;

  // read data stands for the one cycle after the strobe, zero otherwise;
  // pins are taken at the start of the cycle, through the synchroniser
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= gpio_pkg::ZERO_BYTE;
    end else if (CLOCK_ENABLE) begin
      RDATA <= READ ? read_mux : gpio_pkg::ZERO_BYTE;
    end
  end

  // output latches: power-on clears them, other resets leave them alone;
  // the store lands at the end of the strobe cycle
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      latch_a <= gpio_pkg::LATCH_A_RESET;
      latch_b <= gpio_pkg::LATCH_B_RESET;
    end else if (CLOCK_ENABLE) begin
      if (wr_port_a) begin
        latch_a <= WDATA[4:0];
      end
      if (wr_port_b) begin
        latch_b <= WDATA;
      end
    end
  end

  // direction and option registers reset on every kind of reset
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      dir_a   <= gpio_pkg::DIR_A_RESET;
      dir_b   <= gpio_pkg::DIR_B_RESET;
      options <= gpio_pkg::OPTIONS_RESET;
    end else if (CLOCK_ENABLE) begin
      if (OTHER_RESET) begin
        dir_a   <= gpio_pkg::DIR_A_RESET;
        dir_b   <= gpio_pkg::DIR_B_RESET;
        options <= gpio_pkg::OPTIONS_RESET;
      end else begin
        if (wr_dir_a) begin
          dir_a <= WDATA[4:0];
        end
        if (wr_dir_b) begin
          dir_b <= WDATA;
        end
        if (wr_options) begin
          options <= WDATA;
        end
      end
    end
  end

  // comparator and reference control, zero on every reset
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      CMP_CONTROL <= gpio_pkg::CMP_CTRL_RESET;
      REF_CONTROL <= gpio_pkg::REF_CTRL_RESET;
    end else if (CLOCK_ENABLE) begin
      if (OTHER_RESET) begin
        CMP_CONTROL <= gpio_pkg::CMP_CTRL_RESET;
        REF_CONTROL <= gpio_pkg::REF_CTRL_RESET;
      end else begin
        if (wr_cmp) begin
          CMP_CONTROL <= WDATA & gpio_pkg::CMP_CTRL_WR_MASK;
        end
        if (wr_ref) begin
          REF_CONTROL <= WDATA & gpio_pkg::REF_CTRL_WR_MASK;
        end
      end
    end
  end

  // pad drive, pull-up and alternate-function outputs, all registered
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PORT_A_OUT        <= gpio_pkg::LATCH_A_RESET;
      PORT_A_OE         <= gpio_pkg::LATCH_A_RESET;
      PORT_B_OUT        <= gpio_pkg::ZERO_BYTE;
      PORT_B_OE         <= gpio_pkg::ZERO_BYTE;
      PORT_B_PULLUP     <= gpio_pkg::ZERO_BYTE;
      PORT_B_HYSTERESIS <= gpio_pkg::ZERO_BYTE;
      ANALOG_SELECT     <= gpio_pkg::ANALOG_NONE;
      TIMER_CLOCK_PIN   <= 1'b0;
      EXT_INT_PIN       <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      // pin four's data line stays low; its enable alone pulls the pin
      PORT_A_OUT        <= drive_a & ~(5'h01 << gpio_pkg::PIN_OPEN_DRAIN);
      PORT_A_OE         <= next_oe_a;
      PORT_B_OUT        <= latch_b;
      PORT_B_OE         <= ~dir_b;
      PORT_B_PULLUP     <= next_pullup;
      PORT_B_HYSTERESIS <= next_hyst;
      ANALOG_SELECT     <= analog_mask;
      TIMER_CLOCK_PIN   <= pins_a[gpio_pkg::PIN_OPEN_DRAIN];
      EXT_INT_PIN       <= pins_b[gpio_pkg::PIN_EXT_INT];
    end
  end

  // change detector on the upper nibble; its flag is the wake request
  pin_change_detect change_detect (
    .clock      (CLOCK),
    .rst_n      (rst_n),
    .enable     (CLOCK_ENABLE),
    .pins       (pins_b[7:4]),
    .dir        (dir_b[7:4]),
    .capture    (port_b_access),
    .flag_write (wr_int),
    .flag_wdata (WDATA[gpio_pkg::CHANGE_FLAG_BIT]),
    .flag       (change_flag),
    .mismatch   ()
  );

  // a sleeping core only needs the level; the flag register drives it
  assign WAKE_REQUEST = change_flag;

  sequence s_write_port_b;
    CLOCK_ENABLE && wr_port_b;
  endsequence

  sequence s_read_port_a;
    CLOCK_ENABLE && READ && ADDR == gpio_pkg::OFS_PORT_A;
  endsequence

  AST_DIR_RESET: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (CLOCK_ENABLE && OTHER_RESET) |=> (dir_a == 5'h1F && dir_b == 8'hFF))
    else $error("directions not all inputs after reset");

  AST_OPEN_DRAIN: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !PORT_A_OUT[4])
    else $error("open-drain pin drove high");

  AST_FLOAT_INPUT: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (CLOCK_ENABLE && dir_a[1]) |=> !PORT_A_OE[1])
    else $error("input pin of port A is driven");

  AST_ANALOG_READ_ZERO: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (s_read_port_a and analog_mask[0]) |=> !RDATA[0])
    else $error("analog pin read non-zero");

  AST_UNUSED_ZERO: assert property (@(posedge CLOCK) disable iff (!rst_n)
    s_read_port_a |=> RDATA[7:5] == 3'h0)
    else $error("unused port A bits read non-zero");

  AST_PULLUP_OFF_OUTPUT: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (CLOCK_ENABLE && !dir_b[2]) |=> !PORT_B_PULLUP[2])
    else $error("pull-up on while pin is an output");

  AST_PULLUP_ON: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (CLOCK_ENABLE && !options[7] && dir_b[5]) |=> PORT_B_PULLUP[5])
    else $error("pull-up not on with enable bit clear");

  AST_STORE_THEN_DRIVE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    s_write_port_b ##1 CLOCK_ENABLE |=> PORT_B_OUT == $past(WDATA, 2))
    else $error("port B store did not reach the pins");

  AST_CTRL_RESET: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (CLOCK_ENABLE && OTHER_RESET) |=> (CMP_CONTROL == 8'h00 && REF_CONTROL == 8'h00))
    else $error("comparator or reference control not cleared");
endmodule : dual_gpio

// file: verilog/gpio_pkg.sv
// constants for the two-port general-purpose pin block
// assumes a byte-wide register port with the printed register addresses
package gpio_pkg;
  // port widths
  localparam int PORT_A_W = 5;
  localparam int PORT_B_W = 8;
  localparam int CHANGE_W = 4;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 8;

  // register addresses
  localparam logic [7:0] OFS_PORT_A   = 8'h05;
  localparam logic [7:0] OFS_PORT_B   = 8'h06;
  localparam logic [7:0] OFS_INT_CTRL = 8'h0B;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h1F;
  localparam logic [7:0] OFS_OPTIONS  = 8'h81;
  localparam logic [7:0] OFS_DIR_A    = 8'h85;
  localparam logic [7:0] OFS_DIR_B    = 8'h86;
  localparam logic [7:0] OFS_REF_CTRL = 8'h9F;

  // reset values
  localparam logic [7:0] OPTIONS_RESET  = 8'hFF;
  localparam logic [4:0] DIR_A_RESET    = 5'h1F;
  localparam logic [7:0] DIR_B_RESET    = 8'hFF;
  localparam logic [4:0] LATCH_A_RESET  = 5'h00;
  localparam logic [7:0] LATCH_B_RESET  = 8'h00;
  localparam logic [7:0] CMP_CTRL_RESET = 8'h00;
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  // field positions and masks
  localparam int PULLUP_EN_N_BIT   = 7;
  localparam int CHANGE_FLAG_BIT   = 0;
  localparam int REF_OUT_EN_BIT    = 6;
  localparam int FIRST_RESULT_BIT  = 6;
  localparam int SECOND_RESULT_BIT = 7;
  localparam int CMP_MODE_LSB      = 0;
  localparam int CMP_MODE_MSB      = 2;
  localparam int PIN_REF           = 2;
  localparam int PIN_CMP_THREE     = 3;
  localparam int PIN_OPEN_DRAIN    = 4;
  localparam int PIN_EXT_INT       = 0;
  localparam int PIN_PROG_CLOCK    = 6;
  localparam int PIN_PROG_DATA     = 7;
  localparam int CHANGE_LSB        = 4;
  localparam logic [7:0] CMP_CTRL_WR_MASK = 8'h0F;
  localparam logic [7:0] REF_CTRL_WR_MASK = 8'hEF;

  // comparator pin modes and the analog pins they claim
  localparam logic [2:0] CMP_ALL_DIGITAL = 3'h7;
  localparam logic [2:0] CMP_OUTPUTS     = 3'h6;
  localparam logic [4:0] ANALOG_NONE     = 5'h00;
  localparam logic [4:0] ANALOG_OUTMODE  = 5'h07;
  localparam logic [4:0] ANALOG_DEFAULT  = 5'h0F;
endpackage : gpio_pkg

// file: verilog/pin_change_detect.sv
// change detector for the upper port B nibble, with sticky flag
// assumes synchronised pins and one-cycle capture and write strobes
`timescale 1ns/1ps
module pin_change_detect (
  // clock, reset, enable
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       enable,
  // pins and their direction bits
  input  wire logic [3:0] pins,
  input  wire logic [3:0] dir,
  // port access and flag register write
  input  wire logic       capture,
  input  wire logic       flag_write,
  input  wire logic       flag_wdata,
  // sticky flag and live mismatch
  output logic            flag,
  output logic            mismatch
);
  logic [3:0] old_value;
  logic       mismatch_set;
  logic       next_flag;

  // only input pins take part in the comparison
  assign mismatch = |((pins ^ old_value) & dir);
  // a change in the very capture cycle is swallowed, as on the real pin
  assign mismatch_set = mismatch & ~capture;
  // set wins over a software clear, so a standing mismatch re-sets it
  assign next_flag = flag_write ? (flag_wdata | mismatch_set)
                                : (flag | mismatch_set);

  // old value follows every port access, flag is sticky
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      old_value <= 4'h0;
      flag      <= 1'b0;
    end else if (enable) begin
      if (capture) begin
        old_value <= pins;
      end
      flag <= next_flag;
    end
  end

  sequence s_change;
    enable && mismatch && !capture;
  endsequence

  AST_CHANGE_SETS_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    s_change |=> flag)
    else $error("pin change did not set the flag");

  AST_OUTPUTS_EXCLUDED: assert property (@(posedge clock) disable iff (!rst_n)
    (enable && dir == 4'h0 && !flag && !(flag_write && flag_wdata)) |=> !flag)
    else $error("output pin raised the change flag");

  AST_CAPTURE_ENDS_MISMATCH: assert property (@(posedge clock) disable iff (!rst_n)
    (enable && capture) ##1 $stable(pins) |-> !mismatch)
    else $error("port access did not end the mismatch");
endmodule : pin_change_detect

// file: verilog/sync_2ff.sv
// two-flop synchroniser for pin levels
// assumes a synchronous active-low reset copy and a clock enable
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // clock, reset, enable
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             enable,
  // level in and synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
      q     <= '0;
    end else if (enable) begin
      stage <= d;
      q     <= stage;
    end
  end
endmodule : sync_2ff
